// >>> ifsl_top.sv
/*
 Input function and shutoff logic: filters the assignable terminals,
 merges and ranks their functions, evaluates the output shutoff with
 its polarity options, runs the start/stop interlock and selects the
 alternate parameter set.
 Assumes start_cmd and decel_done come from synchronous drive logic and
 that the function map and settings are static while running.
*/
// Overview of operation
// - A function on several terminals is active when any of them is.
// - Speed source ranks jog, then multi-speed selects, then loop control.
// - Unassigned permit or mode-7 interlock follows the shutoff input.
// - Multi-speed and remote setting share the same speed select inputs.
// - V/F switchover request also selects alternate parameters.
// - Control method changes only when stopped; running request selects alt.
// - Current input select disables the voltage speed input.
// - Permit and shutoff respond within 2 ms, other inputs within 20 ms.
// - Shutoff while running cuts the output at once.
// - Function code 24 attaches the shutoff to a terminal.
// - Active shutoff refuses any start command.
// - Start removal decelerates; shutoff lets the motor coast.
// - Polarity 0 normally open, polarity 2 normally closed.
// - Polarity 4: external normally closed, communication normally open.
// - Settings 0 and 2 need both sources off, or both on.
// - Shutoff applies in every operation mode.
// - Alternate select active chooses second set, inactive the first unless a V/F switchover is requested.
// - Function code 3 attaches the alternate select to a terminal.
`timescale 1ns/1ns
module ifsl_top
   import ifsl_pkg::*;
#(
   parameter logic [FILT_W-1:0] FAST_TICKS = FILT_W'(FILT_FAST_TICKS),
   parameter logic [FILT_W-1:0] SLOW_TICKS = FILT_W'(FILT_SLOW_TICKS)
)
(
   // Clock and reset
   input  wire logic                          clock,
   input  wire logic                          arst_n,
   // Contact inputs
   input  wire logic [N_TERM-1:0]             terminal_in,
   input  wire logic                          comm_shutoff_in,
   // Settings
   input  wire logic [N_TERM-1:0][FN_W-1:0]   terminal_function_map,
   input  wire logic [2:0]                    shutoff_polarity_setting,
   input  wire logic [2:0]                    operation_mode_setting,
   input  wire logic                          remote_setting_enable,
   // Drive handshake
   input  wire logic                          start_cmd,
   input  wire logic                          decel_done,
   // Drive control
   output logic                               output_enable,
   output logic                               decel_active,
   output logic                               coast_active,
   output logic                               start_refused,
   output logic                               shutoff_active,
   output logic                               run_permit_ok,
   output logic                               panel_interlock_ok,
   // Parameter set and control method
   output logic                               alt_param_active,
   output logic                               vf_control_active,
   // Speed command
   output ifsl_src_t                          speed_source,
   output logic [3:0]                         speed_select,
   output logic                               remote_clear,
   output logic                               remote_decel,
   output logic                               remote_accel,
   output logic                               current_input_active,
   output logic                               voltage_input_enable
);

   ////////////////////////////////////////////////////////////////////////
   // Decoding helpers
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   // Any terminal with this code whose filtered level is on
   function automatic logic fn_on(
      input logic [N_TERM-1:0][FN_W-1:0] map,
      input logic [N_TERM-1:0]           lvl,
      input logic [FN_W-1:0]             code);
      logic r;
      r = 1'b0;
      for (int i = 0; i < N_TERM; i++)
         r = r | ((map[i] == code) & lvl[i]);
      return r;
   endfunction

   // Any terminal carries this code
   function automatic logic fn_assigned(
      input logic [N_TERM-1:0][FN_W-1:0] map,
      input logic [FN_W-1:0]             code);
      logic r;
      r = 1'b0;
      for (int i = 0; i < N_TERM; i++)
         r = r | (map[i] == code);
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [TICK_W-1:0] tick_cnt;
      logic              tick;
      ifsl_run_t         run;
      logic              out_en;
      logic              decel;
      logic              coast;
      logic              refused;
      logic              shutoff;
      logic              permit_ok;
      logic              ilk_ok;
      logic              alt;
      logic              vf_mode;
      ifsl_src_t         src;
      logic [3:0]        spd;
      logic [2:0]        remote;
      logic              cur;
      logic              volt_en;
   } ifsl_state_t;

   ifsl_state_t q_r;
   ifsl_state_t q_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Filter channels: terminals then communication shutoff
   ifsl_filt_if fif [N_CHAN] ();
   logic [N_TERM-1:0] lvl;
   logic              comm_lvl;

   genvar g;
   generate
      for (g = 0; g < N_TERM; g++)
      begin : g_term
         // Fast filter for the permit and shutoff functions
         assign fif[g].tick  = q_r.tick;
         assign fif[g].raw   = terminal_in[g];
         assign fif[g].limit =
            ((terminal_function_map[g] == FN_SHUTOFF) ||
             (terminal_function_map[g] == FN_RUN_PERMIT)) ?
            FAST_TICKS : SLOW_TICKS;
         assign lvl[g] = fif[g].level;
         ifsl_filt u_filt (
            .clock  (clock),
            .arst_n (arst_n),
            .ch     (fif[g])
         );
      end
   endgenerate

   // Communication shutoff channel
   assign fif[N_TERM].tick  = q_r.tick;
   assign fif[N_TERM].raw   = comm_shutoff_in;
   assign fif[N_TERM].limit = FAST_TICKS;
   assign comm_lvl          = fif[N_TERM].level;

   ifsl_filt u_filt_comm (
      .clock  (clock),
      .arst_n (arst_n),
      .ch     (fif[N_TERM])
   );

   ////////////////////////////////////////////////////////////////////////
   // Decoded functions
   logic ext_off;
   logic shut_ok;
   logic permit_ok;
   logic ilk_ok;
   logic run_ok;
   logic jog_on;
   logic multi_on;
   logic vf_req;
   logic [3:0] sel;

   always_comb
   begin
      // Shutoff from terminals with code 24, ORed
      ext_off = fn_on(terminal_function_map, lvl, FN_SHUTOFF);
      // Polarity table, independent of operation mode
      unique case (shutoff_polarity_setting)
         POL_OPEN:   shut_ok = !ext_off && !comm_lvl;
         POL_CLOSED: shut_ok = ext_off && comm_lvl;
         POL_SPLIT:  shut_ok = ext_off && !comm_lvl;
         default:    shut_ok = 1'b0;
      endcase
      // Permit and interlock fall back onto the shutoff input
      if (fn_assigned(terminal_function_map, FN_RUN_PERMIT))
         permit_ok = fn_on(terminal_function_map, lvl, FN_RUN_PERMIT);
      else
         permit_ok = shut_ok;
      if (operation_mode_setting != OPMODE_ILK)
         ilk_ok = 1'b1;
      else if (fn_assigned(terminal_function_map, FN_INTERLOCK))
         ilk_ok = fn_on(terminal_function_map, lvl, FN_INTERLOCK);
      else
         ilk_ok = shut_ok;
      run_ok = shut_ok && permit_ok;
      // Shared speed selects: low, mid, high, extra
      sel = {fn_on(terminal_function_map, lvl, FN_SPEED_XTRA),
             fn_on(terminal_function_map, lvl, FN_SPEED_HIGH),
             fn_on(terminal_function_map, lvl, FN_SPEED_MID),
             fn_on(terminal_function_map, lvl, FN_SPEED_LOW)};
      jog_on   = fn_on(terminal_function_map, lvl, FN_JOG);
      multi_on = remote_setting_enable ? sel[3] : (sel != 4'h0);
      vf_req   = fn_on(terminal_function_map, lvl, FN_VF_SWITCH);
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      q_nxt = q_r;
      // Tick divider
      q_nxt.tick = (q_r.tick_cnt == TICK_LAST);
      if (q_r.tick_cnt == TICK_LAST)
         q_nxt.tick_cnt = '0;
      else
         q_nxt.tick_cnt = q_r.tick_cnt + 9'h001;
      // Run interlock
      unique case (q_r.run)
         RUN_STOP:
            if (start_cmd && run_ok)
               q_nxt.run = RUN_ON;
         RUN_ON:
            if (!run_ok)
               q_nxt.run = RUN_STOP;
            else if (!start_cmd)
               q_nxt.run = RUN_DECEL;
         RUN_DECEL:
            if (!run_ok)
               q_nxt.run = RUN_STOP;
            else if (start_cmd)
               q_nxt.run = RUN_ON;
            else if (decel_done)
               q_nxt.run = RUN_STOP;
         default:
            q_nxt.run = RUN_STOP;
      endcase
      q_nxt.out_en  = (q_nxt.run != RUN_STOP);
      q_nxt.decel   = (q_nxt.run == RUN_DECEL);
      // Coast held from the cut until the next start
      q_nxt.coast   = ((q_r.run != RUN_STOP) && !run_ok) ||
                      (q_r.coast && (q_nxt.run == RUN_STOP));
      q_nxt.refused = start_cmd && !run_ok;
      q_nxt.shutoff = !shut_ok;
      q_nxt.permit_ok = permit_ok;
      q_nxt.ilk_ok  = ilk_ok;
      // Alternate set from its select or the switchover request
      q_nxt.alt = fn_on(terminal_function_map, lvl, FN_ALT_PARAM) ||
                  vf_req;
      // Control method only follows while stopped
      if ((q_r.run == RUN_STOP) && (q_nxt.run == RUN_STOP))
         q_nxt.vf_mode = vf_req;
      // Speed command ranking
      if (jog_on)
         q_nxt.src = SRC_JOG;
      else if (multi_on)
         q_nxt.src = SRC_MULTI;
      else if (fn_on(terminal_function_map, lvl, FN_LOOP_CTRL))
         q_nxt.src = SRC_LOOP;
      else
         q_nxt.src = SRC_NONE;
      // Same selects act as speed bits or remote commands
      if (remote_setting_enable)
      begin
         q_nxt.spd    = {sel[3], 3'h0};
         q_nxt.remote = sel[2:0];
      end
      else
      begin
         q_nxt.spd    = sel;
         q_nxt.remote = 3'h0;
      end
      q_nxt.cur     = fn_on(terminal_function_map, lvl, FN_CUR_INPUT);
      q_nxt.volt_en = !q_nxt.cur;
   end

   // State register
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         q_r <= '0;
      else
         q_r <= q_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register
   assign output_enable        = q_r.out_en;
   assign decel_active         = q_r.decel;
   assign coast_active         = q_r.coast;
   assign start_refused        = q_r.refused;
   assign shutoff_active       = q_r.shutoff;
   assign run_permit_ok        = q_r.permit_ok;
   assign panel_interlock_ok   = q_r.ilk_ok;
   assign alt_param_active     = q_r.alt;
   assign vf_control_active    = q_r.vf_mode;
   assign speed_source         = q_r.src;
   assign speed_select         = q_r.spd;
   assign remote_clear         = q_r.remote[0];
   assign remote_decel         = q_r.remote[1];
   assign remote_accel         = q_r.remote[2];
   assign current_input_active = q_r.cur;
   assign voltage_input_enable = q_r.volt_en;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   sequence seq_running;
      output_enable && !decel_active;
   endsequence

   sequence seq_cut;
      !run_ok;
   endsequence

   chk_or_merge: assert property (
      alt_param_active ==
      ($past(fn_on(terminal_function_map, lvl, FN_ALT_PARAM)) ||
       $past(vf_req)))
      else $error("alternate select does not follow merged terminals");

   chk_speed_rank: assert property (
      $past(jog_on) |-> speed_source == SRC_JOG)
      else $error("jog did not win the speed ranking");

   chk_shutoff_share: assert property (
      $past(arst_n) &&
      !$past(fn_assigned(terminal_function_map, FN_RUN_PERMIT)) |->
      run_permit_ok == !shutoff_active)
      else $error("permit did not follow the shutoff input");

   chk_shared_sel: assert property (
      $past(remote_setting_enable) |-> speed_select[2:0] == 3'h0)
      else $error("speed bits active in remote setting mode");

   chk_vf_alt: assert property (
      $past(vf_req) |-> alt_param_active)
      else $error("switchover did not select alternate set");

   chk_vf_hold: assert property (
      output_enable |=> $stable(vf_control_active))
      else $error("control method changed while running");

   chk_volt_mask: assert property (
      current_input_active |-> !voltage_input_enable)
      else $error("voltage input enabled with current select");

   chk_cut_now: assert property (
      seq_running ##0 seq_cut |=> !output_enable && coast_active)
      else $error("shutoff did not cut output at once");

   chk_no_start: assert property (
      shutoff_active |-> !output_enable)
      else $error("output enabled while shutoff active");

   chk_decel_ramp: assert property (
      seq_running ##0 (run_ok && !start_cmd) |=> decel_active && !coast_active)
      else $error("start removal did not decelerate");

   chk_pol_split: assert property (
      (shutoff_polarity_setting == POL_SPLIT) |=>
      shutoff_active == !($past(ext_off) && !$past(comm_lvl)))
      else $error("split polarity shutoff wrong");

   chk_pol_closed: assert property (
      (shutoff_polarity_setting == POL_CLOSED) |=>
      shutoff_active == !($past(ext_off) && $past(comm_lvl)))
      else $error("closed polarity shutoff wrong");

endmodule

// >>> ifsl_pkg.sv
/*
 Shared constants and types for the input function and shutoff logic:
 terminal function codes, shutoff polarity settings, timing counts.
 Assumes a 50 MHz system clock and five assignable input terminals.
*/
package ifsl_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Terminal count and function code width
   localparam int N_TERM = 5;
   localparam int N_CHAN = N_TERM + 1;
   localparam int FN_W   = 14;

   ////////////////////////////////////////////////////////////////////////
   // Function codes held in the terminal function map
   localparam logic [FN_W-1:0] FN_SPEED_LOW  = 14'h0000;
   localparam logic [FN_W-1:0] FN_SPEED_MID  = 14'h0001;
   localparam logic [FN_W-1:0] FN_SPEED_HIGH = 14'h0002;
   localparam logic [FN_W-1:0] FN_ALT_PARAM  = 14'h0003;
   localparam logic [FN_W-1:0] FN_CUR_INPUT  = 14'h0004;
   localparam logic [FN_W-1:0] FN_JOG        = 14'h0005;
   localparam logic [FN_W-1:0] FN_SPEED_XTRA = 14'h0008;
   localparam logic [FN_W-1:0] FN_RUN_PERMIT = 14'h000a;
   localparam logic [FN_W-1:0] FN_INTERLOCK  = 14'h000c;
   localparam logic [FN_W-1:0] FN_LOOP_CTRL  = 14'h000e;
   localparam logic [FN_W-1:0] FN_VF_SWITCH  = 14'h0012;
   localparam logic [FN_W-1:0] FN_SHUTOFF    = 14'h0018;
   localparam logic [FN_W-1:0] FN_NONE       = 14'h270f;

   ////////////////////////////////////////////////////////////////////////
   // Shutoff polarity settings and operation mode
   localparam logic [2:0] POL_OPEN   = 3'h0;
   localparam logic [2:0] POL_CLOSED = 3'h2;
   localparam logic [2:0] POL_SPLIT  = 3'h4;
   localparam logic [2:0] OPMODE_ILK = 3'h7;

   ////////////////////////////////////////////////////////////////////////
   // Timing: clock, tick divider, response and filter times
   localparam int CLK_MHZ      = 50;
   localparam int TICK_US      = 10;
   localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;
   localparam int TICK_W       = 9;
   localparam int RESP_FAST_MS = 2;
   localparam int RESP_SLOW_MS = 20;
   localparam int FILT_FAST_US = RESP_FAST_MS * 1000 / 2;
   localparam int FILT_SLOW_US = RESP_SLOW_MS * 1000 / 2;
   localparam int FILT_W       = 10;
   localparam int FILT_FAST_TICKS = FILT_FAST_US / TICK_US;
   localparam int FILT_SLOW_TICKS = FILT_SLOW_US / TICK_US;

   ////////////////////////////////////////////////////////////////////////
   // Speed command source and run state
   typedef enum logic [1:0] {
      SRC_NONE  = 2'b00,
      SRC_JOG   = 2'b01,
      SRC_MULTI = 2'b10,
      SRC_LOOP  = 2'b11
   } ifsl_src_t;

   typedef enum logic [1:0] {
      RUN_STOP  = 2'b00,
      RUN_ON    = 2'b01,
      RUN_DECEL = 2'b10
   } ifsl_run_t;

endpackage

// >>> ifsl_filt_if.sv
/*
 Carrier between the decoder and one input filter channel.
 Assumes tick is a one-cycle enable from the decoder's divider.
*/
`timescale 1ns/1ns
interface ifsl_filt_if;
   import ifsl_pkg::*;
   logic              tick;
   logic [FILT_W-1:0] limit;
   logic              raw;
   logic              level;

   modport ctrl (output tick, output limit, output raw, input level);
   modport filt (input tick, input limit, input raw, output level);
endinterface

// >>> ifsl_filt.sv
/*
 One input channel: two-stage synchroniser and a stability filter.
 Assumes raw is a contact level; limit counts ticks of stable change.
*/
`timescale 1ns/1ns
module ifsl_filt
   import ifsl_pkg::*;
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic arst_n,
   // Channel
   ifsl_filt_if.filt ch
);

   typedef struct packed {
      logic              s1;
      logic              s2;
      logic              level;
      logic [FILT_W-1:0] cnt;
   } ifsl_filt_st_t;

   ifsl_filt_st_t q_r;
   ifsl_filt_st_t q_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Next state: level follows s2 once stable for limit ticks
   always_comb
   begin
      q_nxt    = q_r;
      q_nxt.s1 = ch.raw;
      q_nxt.s2 = q_r.s1;
      if (q_r.s2 == q_r.level)
      begin
         q_nxt.cnt = '0;
      end
      else if (ch.tick)
      begin
         if ((q_r.cnt + 10'h001) >= ch.limit)
         begin
            q_nxt.level = q_r.s2;
            q_nxt.cnt   = '0;
         end
         else
         begin
            q_nxt.cnt = q_r.cnt + 10'h001;
         end
      end
   end

   // State register
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         q_r <= '0;
      else
         q_r <= q_nxt;
   end

   assign ch.level = q_r.level;

   ////////////////////////////////////////////////////////////////////////
   // Bound on how long a settled change may wait
   logic [19:0] mis_cnt;
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         mis_cnt <= '0;
      else if (q_r.s2 == q_r.level)
         mis_cnt <= '0;
      else
         mis_cnt <= mis_cnt + 20'h00001;
   end

   chk_filt_bound: assert property (@(posedge clock) disable iff (!arst_n)
      mis_cnt <= ({10'h000, ch.limit} + 20'h00001) * 20'(TICK_CYCLES))
      else $error("filtered level waited past its limit");

endmodule

// >>> ifsl_contacts.sv
/*
 Contact model for the assignable terminals and the comm shutoff source.
 Assumes the bench sets the wanted levels; each change chatters briefly.
*/
`timescale 1ns/1ns
module ifsl_contacts
(
   // Clock
   input  wire logic       clock,
   // Wanted contact levels
   input  wire logic [4:0] want,
   input  wire logic       want_comm,
   // Contact levels seen by the block
   output logic [4:0]      terminal_in,
   output logic            comm_shutoff_in
);
   logic [5:0] last = 6'h00;
   int         bounce = 0;

   ////////////////////////////////////////////////////////////////////////
   // Chatter for a few cycles, far shorter than any filter time
   always @(posedge clock)
   begin
      #2;                                     // After the bench's drive
      if ({want_comm, want} !== last)
      begin
         last = {want_comm, want};
         bounce = 4;
      end
      if (bounce > 0)
         bounce--;
      {comm_shutoff_in, terminal_in} = bounce[0] ? ~last : last;
   end
endmodule

// >>> tb_top.sv
/*
 Self-checking bench for the input function and shutoff logic.
 Assumes short filter counts of 2 and 4 ticks for a quick run.
*/
`timescale 1ns/1ns
module tb_top;
   import ifsl_pkg::*;
   logic clock = 0, arst_n = 0, start_cmd = 0, decel_done = 0;
   logic [4:0] want = 5'h00, t_in;
   logic want_comm = 0, c_in, rse = 0;
   logic [N_TERM-1:0][FN_W-1:0] fmap;
   logic [2:0] pol = 3'h0, opm = 3'h0;
   logic oe, dec, cst, refu, sa, rpo, pio, alt, vfc, rc, rd, ra, cia, vie;
   ifsl_src_t src;
   logic [3:0] ssel;
   int fail_count = 0, n_tests = 0, cyc = 0;
   logic [12:0] rows [14] = '{13'h0000, 13'h0108, 13'h0208, 13'h0088,
      13'h01a0, 13'h0128, 13'h0028, 13'h0240, 13'h01c8, 13'h0048,
      13'h0058, 13'h0404, 13'h1004, 13'h0801};

   ////////////////////////////////////////////////////////////////////////
   // Clock and cycle ceiling
   initial forever #10 clock = ~clock;
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         fail_count++;
         stop_test();
      end
   end

   ifsl_contacts partner (.clock(clock), .want(want), .want_comm(want_comm),
      .terminal_in(t_in), .comm_shutoff_in(c_in));

   ifsl_top #(.FAST_TICKS(10'h002), .SLOW_TICKS(10'h004)) uut (
      .clock(clock), .arst_n(arst_n), .terminal_in(t_in),
      .comm_shutoff_in(c_in), .terminal_function_map(fmap),
      .shutoff_polarity_setting(pol), .operation_mode_setting(opm),
      .remote_setting_enable(rse), .start_cmd(start_cmd),
      .decel_done(decel_done), .output_enable(oe), .decel_active(dec),
      .coast_active(cst), .start_refused(refu), .shutoff_active(sa),
      .run_permit_ok(rpo), .panel_interlock_ok(pio),
      .alt_param_active(alt), .vf_control_active(vfc),
      .speed_source(src), .speed_select(ssel), .remote_clear(rc),
      .remote_decel(rd), .remote_accel(ra), .current_input_active(cia),
      .voltage_input_enable(vie));

   ////////////////////////////////////////////////////////////////////////
   // Compare, count and report
   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Wait cycles, then step past the edge
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      fmap = {FN_VF_SWITCH, FN_JOG, FN_ALT_PARAM, FN_SHUTOFF, FN_SHUTOFF};
      wait_cyc(8);
      arst_n = 1;
      wait_cyc(2);
      check(vie, 4'h1);
      check(sa, 4'h0);
      check(oe, 4'h0);
      // Polarity table, merged terminals, alt select, jog
      foreach (rows[i])
      begin
         {want, want_comm, pol} = rows[i][12:4];
         wait_cyc(3000);
         check(sa, rows[i][3]);
         check(rpo, !rows[i][3]);
         check(alt, rows[i][2]);
         check(src, rows[i][1:0]);
      end
      {want, want_comm, pol} = 9'h000;
      wait_cyc(3000);
      // Run, switchover while running, then shutoff
      start_cmd = 1;
      wait_cyc(3);
      check(oe, 4'h1);
      want = 5'h10;
      wait_cyc(3000);
      check(alt, 4'h1);
      check(vfc, 4'h0);
      want = 5'h11;
      wait_cyc(3000);
      check({oe, cst, refu}, 4'h3);
      check(vfc, 4'h1);
      want = 5'h00;
      start_cmd = 0;
      wait_cyc(3000);
      // Start removal ramps down instead of coasting
      start_cmd = 1;
      wait_cyc(3);
      start_cmd = 0;
      wait_cyc(3);
      check({oe, dec, cst}, 4'h6);
      decel_done = 1;
      wait_cyc(3);
      check({oe, dec}, 4'h0);
      decel_done = 0;
      // Speed ranking and current input select on slow terminals
      fmap = {FN_LOOP_CTRL, FN_SPEED_LOW, FN_CUR_INPUT, FN_SHUTOFF,
              FN_SHUTOFF};
      want = 5'h18;
      wait_cyc(3000);
      check(src, SRC_MULTI);
      check(ssel, 4'h1);
      want = 5'h10;
      wait_cyc(3000);
      check(src, SRC_LOOP);
      want = 5'h04;
      wait_cyc(3000);
      check({cia, vie}, 4'h2);
      // Remote mode on the shared selects, unassigned mode-7 interlock
      rse = 1;
      opm = 3'h7;
      want = 5'h19;
      wait_cyc(3000);
      check({ra, rd, rc}, 4'h1);
      check(ssel, 4'h0);
      check(src, SRC_LOOP);
      check({sa, pio}, 4'h2);
      // Assigned permit and interlock, jog over a multi-speed select
      rse = 0;
      fmap = {FN_INTERLOCK, FN_JOG, FN_SPEED_MID, FN_RUN_PERMIT,
              FN_SHUTOFF};
      want = 5'h0e;
      wait_cyc(3000);
      check(src, SRC_JOG);
      check(ssel, 4'h2);
      check({sa, rpo, pio}, 4'h2);
      // Reset while stopped with terminals on: outputs clear, filters restart from off
      arst_n = 0;
      wait_cyc(2);
      check({vie, rpo, src}, 4'h0);
      arst_n = 1;
      wait_cyc(2);
      check({vie, src}, 4'h4);
      want = 5'h10;
      wait_cyc(3000);
      check({sa, rpo, pio}, 4'h1);
      check(src, SRC_NONE);
      stop_test();
   end
endmodule
